// ===== hdl/lpd_regs.sv
// low-power domain control register bank with timer, sleep sequencing
// assumes: register port synchronous to CLOCK; SLOW_CLK and wake pins
// are asynchronous and are synchronised here
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// - request bit copies running timer into readout
// - valid flag sets once readout refreshed
// - readout split into 32-bit low, 16-bit high
// - writable 48-bit sleep target, low and high
// - alarm arm enables timer-versus-target comparison
// - write-only system and per-cpu reset triggers
// - sleep lasts at least programmed slow cycles
// - oscillator stays on programmed slow cycles first
// - coprocessor and touch start after programmed delay
// - analogue power bit one means sub-block on
// - force on/off bits for crystal, pll, bias, buses
// - block or force core reset in deep sleep
// - sleep request, reject, wake and timer enables
// - cpu stall enable bit permits stalling
// - boot vector selects and read-only reset causes
// - optional filter on pin wake events
// - masked wake sources, cause reported read-only
// - each interrupt source gated by its enable
module lpd_regs
	import lpd_pkg::*;
(
	input wire logic CLOCK,                   // 200 MHz system clock
	input wire logic RESETN,                  // async reset, active low
	input wire logic [3:0] REG_ADDR,          // register word index
	input wire logic REG_WR,                  // write strobe
	input wire logic REG_RD,                  // read strobe
	input wire logic [31:0] REG_WDATA,        // write data
	output logic [31:0] REG_RDATA,            // read data, next cycle
	input wire logic SLOW_CLK,                // slow clock pin
	input wire logic [9:0] WAKE_IN,           // wake source pins
	input wire logic [CAUSE_W-1:0] PRI_CAUSE_IN, // primary cpu reset cause
	input wire logic [CAUSE_W-1:0] SEC_CAUSE_IN, // secondary cpu cause
	input wire logic [IRQ_W-1:0] IRQ_SRC,     // external irq events
	output logic [IRQ_W-1:0] IRQ_OUT,         // gated irq events
	output lpd_pwr_s PWR_CTRL,                // power force controls
	output logic SYS_RESET_PULSE,             // system soft reset
	output logic PRI_RESET_PULSE,             // primary cpu soft reset
	output logic SEC_RESET_PULSE,             // secondary cpu soft reset
	output logic CPU_STALL_EN,                // cpu stall permitted
	output logic [1:0] BOOT_VEC_SEL,          // boot vector per cpu
	output logic SLEEP_ACTIVE,                // domain is asleep
	output logic OSC_ON,                      // fast oscillator enable
	output logic COPROC_RUN,                  // coprocessor may run
	output logic TOUCH_RUN                    // touch controller may run
);

	// ------------------------------------------------------------
	// storage
	// ------------------------------------------------------------
	logic [31:0] opt_q;            // options read/write bits
	logic [31:0] tgt_lo_q;         // sleep target low word
	logic [15:0] tgt_hi_q;         // sleep target high field
	logic alarm_arm_q;             // alarm comparison armed
	logic [47:0] timer_q;          // running slow-clock timer
	logic [47:0] latch_q;          // latched readout
	logic latch_req_q;             // latch pending next cycle
	logic latch_valid_q;           // readout refreshed
	logic [4:0] ss_q;              // sleep state control bits
	logic stall_q;                 // cpu stall enable
	logic [7:0] osc_min_q;         // oscillator minimum on cycles
	logic [15:0] start_dly_q;      // coprocessor/touch start delay
	logic [15:0] min_slp_q;        // minimum sleep cycles
	logic [6:0] ana_q;             // analogue power configuration
	logic [1:0] vsel_q;            // boot vector selects
	logic filt_en_q;               // pin wake filter enable
	logic [WAKE_W-1:0] wmask_q;    // wake source mask
	logic [WAKE_W-1:0] wcause_q;   // last wake cause
	logic [IRQ_W-1:0] irq_en_q;    // interrupt enables
	logic [31:0] rdata_q;          // read data register
	logic [2:0] rst_pulse_q;       // soft reset pulses
	logic [IRQ_W-1:0] irq_q;       // gated interrupt pulses
	lpd_state_e state_q;           // sleep sequencer state
	logic [15:0] slp_cnt_q;        // slow cycles spent asleep
	logic osc_on_q;                // oscillator enable
	logic coproc_q;                // coprocessor run
	logic touch_q;                 // touch run
	logic alarm_hit_q;             // timer reached target
	logic alarm_hit_d1_q;          // previous alarm_hit, edge detect
	logic valid_d1_q;              // previous valid, edge detect

	// synchronisers: first stage read only by second
	logic [2:0] slow_sync_q;       // [0]/[1] sync, [2] edge history
	logic [9:0] wake_s1_q;
	logic [9:0] wake_s2_q;
	logic [2*CAUSE_W-1:0] cause_s1_q;
	logic [2*CAUSE_W-1:0] cause_s2_q;
	logic [3:0] filt_cnt_q;        // pin wake stability count
	logic filt_last_q;             // last pin wake sample
	logic filt_out_q;              // filtered pin wake

	logic wr_hit_opt, slow_tick, wake_hit, pin_wake;
	logic [WAKE_W-1:0] wake_vec;
	logic [31:0] rdata_d;

	// write decode helper used by every process that takes a register write
	function automatic logic wr_at(input logic [3:0] idx);
		return REG_WR && (REG_ADDR == idx);
	endfunction

	// ------------------------------------------------------------
	// input synchronisers and slow clock edge
	// ------------------------------------------------------------
	// two flops on every asynchronous input before any logic
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			slow_sync_q <= 3'h0;
			wake_s1_q <= 10'h000;
			wake_s2_q <= 10'h000;
			cause_s1_q <= 12'h000;
			cause_s2_q <= 12'h000;
		end else begin
			slow_sync_q <= {slow_sync_q[1:0], SLOW_CLK};
			wake_s1_q <= WAKE_IN;
			wake_s2_q <= wake_s1_q;
			cause_s1_q <= {SEC_CAUSE_IN, PRI_CAUSE_IN};
			cause_s2_q <= cause_s1_q;
		end
	end

	// rising edge of the synchronised slow clock
	assign slow_tick = slow_sync_q[1] && !slow_sync_q[2];

	// ------------------------------------------------------------
	// pin wake filter
	// ------------------------------------------------------------
	// pin 0 must hold a level for a run of samples; trades latency
	// for immunity to glitches on a long board trace
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			filt_cnt_q <= 4'h0;
			filt_last_q <= 1'b0;
			filt_out_q <= 1'b0;
		end else begin
			filt_last_q <= wake_s2_q[0];
			if (wake_s2_q[0] != filt_last_q) begin
				filt_cnt_q <= 4'h0;          // level moved, restart
			end else if (filt_cnt_q != PIN_FILTER_CYCLES) begin
				filt_cnt_q <= filt_cnt_q + 4'h1;
			end else begin
				filt_out_q <= filt_last_q;   // stable long enough
			end
		end
	end

	assign pin_wake = filt_en_q ? filt_out_q : wake_s2_q[0];
	assign wake_vec = {alarm_hit_q, wake_s2_q[9:1], pin_wake};
	assign wake_hit = |(wake_vec & wmask_q);

	// ------------------------------------------------------------
	// configuration registers
	// ------------------------------------------------------------
	// plain read/write storage steering the outputs
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			opt_q <= OPT_RESET;
			tgt_lo_q <= 32'h0;
			tgt_hi_q <= 16'h0;
			alarm_arm_q <= 1'b0;
			stall_q <= 1'b0;
			osc_min_q <= 8'h0;
			start_dly_q <= 16'h0;
			min_slp_q <= 16'h0;
			ana_q <= 7'h0;
			vsel_q <= 2'h0;
			filt_en_q <= 1'b0;
			wmask_q <= 11'h0;
			irq_en_q <= 9'h0;
		end else begin
			if (wr_hit_opt)
				opt_q <= REG_WDATA & OPT_RW_MASK;
			if (wr_at(IDX_SLEEP_TARGET_LOW))
				tgt_lo_q <= REG_WDATA;
			if (wr_at(IDX_SLEEP_TARGET_HIGH_ALARM)) begin
				tgt_hi_q <= REG_WDATA[15:0];
				alarm_arm_q <= REG_WDATA[ALARM_ARM_BIT];
			end
			if (wr_at(IDX_CPU_STALL_CTRL))
				stall_q <= REG_WDATA[0];
			if (wr_at(IDX_SLOW_CLOCK_WAIT_CFG)) begin
				osc_min_q <= REG_WDATA[7:0];
				start_dly_q <= REG_WDATA[WAIT_DELAY_LSB +: 16];
			end
			if (wr_at(IDX_MIN_SLEEP_CFG))
				min_slp_q <= REG_WDATA[15:0];
			if (wr_at(IDX_ANALOG_POWER_CFG))
				ana_q <= REG_WDATA[6:0];
			if (wr_at(IDX_RESET_STATE))
				vsel_q <= REG_WDATA[1:0];
			if (wr_at(IDX_WAKEUP_STATE)) begin
				filt_en_q <= REG_WDATA[0];
				wmask_q <= REG_WDATA[WS_MASK_LSB +: WAKE_W];
			end
			if (wr_at(IDX_IRQ_ENABLE))
				irq_en_q <= REG_WDATA[IRQ_W-1:0];
		end
	end

	assign wr_hit_opt = wr_at(IDX_DOMAIN_OPTIONS);

	// ------------------------------------------------------------
	// soft reset triggers
	// ------------------------------------------------------------
	// one-cycle pulses; the bits themselves are never stored
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			rst_pulse_q <= 3'h0;
		end else begin
			rst_pulse_q[0] <= wr_hit_opt && REG_WDATA[OPT_SOFT_SYSTEM_RESET];
			rst_pulse_q[1] <= wr_hit_opt && REG_WDATA[OPT_SOFT_PRIMARY_CPU_RESET];
			rst_pulse_q[2] <= wr_hit_opt && REG_WDATA[OPT_SOFT_SECONDARY_CPU_RESET];
		end
	end

	// ------------------------------------------------------------
	// running timer and latched readout
	// ------------------------------------------------------------
	// timer advances once per slow clock rising edge
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			timer_q <= 48'h0;
		end else if (slow_tick) begin
			timer_q <= timer_q + 48'h1;
		end
	end

	// request clears valid; the copy one cycle later sets it again.
	// latch_q only moves on a request, so both words stay coherent
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			latch_req_q <= 1'b0;
			latch_q <= 48'h0;
			latch_valid_q <= 1'b0;
		end else begin
			latch_req_q <= wr_at(IDX_TIMER_LATCH_CTRL) && REG_WDATA[LATCH_REQ_BIT];
			if (latch_req_q) begin
				latch_q <= timer_q;
				latch_valid_q <= 1'b1;
			end else if (wr_at(IDX_TIMER_LATCH_CTRL) && REG_WDATA[LATCH_REQ_BIT]) begin
				latch_valid_q <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// alarm comparison
	// ------------------------------------------------------------
	// compare only while armed; a disarmed alarm reads as no hit
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			alarm_hit_q <= 1'b0;
		end else begin
			alarm_hit_q <= alarm_arm_q && (timer_q >= {tgt_hi_q, tgt_lo_q});
		end
	end

	// ------------------------------------------------------------
	// sleep sequencer
	// ------------------------------------------------------------
	// sleep request enters sleep unless a wake is already pending,
	// in which case the request is rejected at once
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			state_q <= ST_AWAKE;
			ss_q <= 5'h0;
			slp_cnt_q <= 16'h0;
			wcause_q <= 11'h0;
		end else begin
			// software write first, hardware updates below override
			if (wr_at(IDX_SLEEP_STATE_CTRL))
				ss_q <= REG_WDATA[4:0];
			case (state_q)
				ST_AWAKE: begin
					slp_cnt_q <= 16'h0;
					if (ss_q[SS_SLEEP_REQUEST]) begin
						if (wake_hit) begin
							ss_q[SS_SLEEP_REQUEST] <= 1'b0;
							ss_q[SS_REJECT] <= 1'b1;       // set beats clear
						end else begin
							state_q <= ST_SLEEP;
						end
					end
				end
				ST_SLEEP: begin
					if (slow_tick && slp_cnt_q != 16'hffff)
						slp_cnt_q <= slp_cnt_q + 16'h1;
					// wake only after the minimum sleep has elapsed
					if (wake_hit && slp_cnt_q >= min_slp_q) begin
						state_q <= ST_AWAKE;
						wcause_q <= wake_vec & wmask_q;
						ss_q[SS_SLEEP_REQUEST] <= 1'b0;
						ss_q[SS_WAKE] <= 1'b1;             // set beats clear
					end
				end
				default: begin
					state_q <= ST_AWAKE;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// oscillator and coprocessor/touch gating
	// ------------------------------------------------------------
	// counts reuse the sleep cycle count so all three share one time base
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			osc_on_q <= 1'b1;
			coproc_q <= 1'b0;
			touch_q <= 1'b0;
		end else begin
			osc_on_q <= (state_q != ST_SLEEP) ||
				(slp_cnt_q < {8'h0, osc_min_q});
			coproc_q <= (state_q == ST_SLEEP) && ss_q[SS_COPROC_TIMER] &&
				(slp_cnt_q >= start_dly_q);
			touch_q <= (state_q == ST_SLEEP) && ss_q[SS_TOUCH_TIMER] &&
				(slp_cnt_q >= start_dly_q);
		end
	end

	// ------------------------------------------------------------
	// interrupt gating
	// ------------------------------------------------------------
	// timer and valid events are rising edges, reject and wake are levels; a cleared enable blocks all
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			alarm_hit_d1_q <= 1'b0;
			valid_d1_q <= 1'b0;
			irq_q <= 9'h0;
		end else begin
			alarm_hit_d1_q <= alarm_hit_q;
			valid_d1_q <= latch_valid_q;
			irq_q <= (IRQ_SRC |
				(9'(alarm_hit_q && !alarm_hit_d1_q) << IRQ_MAIN_TIMER) |
				(9'(latch_valid_q && !valid_d1_q) << IRQ_TIME_VALID) |
				(9'(ss_q[SS_REJECT]) << IRQ_SLEEP_REJECT) |
				(9'(ss_q[SS_WAKE]) << IRQ_SLEEP_WAKE)) & irq_en_q;
		end
	end

	// ------------------------------------------------------------
	// read path
	// ------------------------------------------------------------
	// unmapped indices and write-only bits read as zero
	always_comb begin
		rdata_d = 32'h0;
		case (REG_ADDR)
			IDX_DOMAIN_OPTIONS: rdata_d = opt_q;
			IDX_SLEEP_TARGET_LOW: rdata_d = tgt_lo_q;
			IDX_SLEEP_TARGET_HIGH_ALARM: begin
				rdata_d[15:0] = tgt_hi_q;
				rdata_d[ALARM_ARM_BIT] = alarm_arm_q;
			end
			IDX_TIMER_LATCH_CTRL: rdata_d[LATCH_VALID_BIT] = latch_valid_q;
			IDX_TIMER_VALUE_LOW: rdata_d = latch_q[31:0];
			IDX_TIMER_VALUE_HIGH: rdata_d[15:0] = latch_q[47:32];
			IDX_SLEEP_STATE_CTRL: rdata_d[4:0] = ss_q;
			IDX_CPU_STALL_CTRL: rdata_d[0] = stall_q;
			IDX_SLOW_CLOCK_WAIT_CFG: begin
				rdata_d[7:0] = osc_min_q;
				rdata_d[WAIT_DELAY_LSB +: 16] = start_dly_q;
			end
			IDX_MIN_SLEEP_CFG: rdata_d[15:0] = min_slp_q;
			IDX_ANALOG_POWER_CFG: rdata_d[6:0] = ana_q;
			IDX_RESET_STATE: begin
				rdata_d[1:0] = vsel_q;
				rdata_d[RS_CAUSE_PRI_LSB +: CAUSE_W] = cause_s2_q[CAUSE_W-1:0];
				rdata_d[RS_CAUSE_SEC_LSB +: CAUSE_W] = cause_s2_q[2*CAUSE_W-1:CAUSE_W];
			end
			IDX_WAKEUP_STATE: begin
				rdata_d[0] = filt_en_q;
				rdata_d[WS_MASK_LSB +: WAKE_W] = wmask_q;
				rdata_d[WS_CAUSE_LSB +: WAKE_W] = wcause_q;
			end
			IDX_IRQ_ENABLE: rdata_d[IRQ_W-1:0] = irq_en_q;
			default: rdata_d = 32'h0;
		endcase
	end

	// read data registered; holds between reads
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			rdata_q <= 32'h0;
		end else if (REG_RD) begin
			rdata_q <= rdata_d;
		end
	end

	// ------------------------------------------------------------
	// outputs, all taken from flops
	// ------------------------------------------------------------
	assign REG_RDATA = rdata_q;
	assign IRQ_OUT = irq_q;
	assign PWR_CTRL.ana_power_on = ana_q[4:0];
	assign PWR_CTRL.plla_force_on = ana_q[5];
	assign PWR_CTRL.plla_force_off = ana_q[6];
	assign PWR_CTRL.force_bits = opt_q[16:1];
	assign SYS_RESET_PULSE = rst_pulse_q[0];
	assign PRI_RESET_PULSE = rst_pulse_q[1];
	assign SEC_RESET_PULSE = rst_pulse_q[2];
	assign CPU_STALL_EN = stall_q;
	assign BOOT_VEC_SEL = vsel_q;
	assign SLEEP_ACTIVE = (state_q == ST_SLEEP);
	assign OSC_ON = osc_on_q;
	assign COPROC_RUN = coproc_q;
	assign TOUCH_RUN = touch_q;

endmodule

`default_nettype wire

// ===== hdl/lpd_pkg.sv
// low-power domain control register bank: shared constants and types
// assumes one 200 MHz clock; slow-clock edges arrive on a pin and are
// sampled as ordinary inputs
package lpd_pkg;

	// ------------------------------------------------------------
	// register indices (word index on the register port)
	// ------------------------------------------------------------
	localparam logic [3:0] IDX_DOMAIN_OPTIONS = 4'h0;
	localparam logic [3:0] IDX_SLEEP_TARGET_LOW = 4'h1;
	localparam logic [3:0] IDX_SLEEP_TARGET_HIGH_ALARM = 4'h2;
	localparam logic [3:0] IDX_TIMER_LATCH_CTRL = 4'h3;
	localparam logic [3:0] IDX_TIMER_VALUE_LOW = 4'h4;
	localparam logic [3:0] IDX_TIMER_VALUE_HIGH = 4'h5;
	localparam logic [3:0] IDX_SLEEP_STATE_CTRL = 4'h6;
	localparam logic [3:0] IDX_CPU_STALL_CTRL = 4'h7;
	localparam logic [3:0] IDX_SLOW_CLOCK_WAIT_CFG = 4'h8;
	localparam logic [3:0] IDX_MIN_SLEEP_CFG = 4'hb;
	localparam logic [3:0] IDX_ANALOG_POWER_CFG = 4'hc;
	localparam logic [3:0] IDX_RESET_STATE = 4'hd;
	localparam logic [3:0] IDX_WAKEUP_STATE = 4'he;
	localparam logic [3:0] IDX_IRQ_ENABLE = 4'hf;

	// ------------------------------------------------------------
	// domain_options field positions
	// ------------------------------------------------------------
	localparam int OPT_SOFT_SYSTEM_RESET = 0;
	localparam int OPT_SOFT_PRIMARY_CPU_RESET = 17;
	localparam int OPT_SOFT_SECONDARY_CPU_RESET = 18;
	// read/write bits 1..16; write-only triggers read as zero
	localparam logic [31:0] OPT_RW_MASK = 32'h0001_fffe;
	localparam logic [31:0] OPT_RESET = 32'h0000_0000;

	// ------------------------------------------------------------
	// other field positions and widths
	// ------------------------------------------------------------
	localparam int ALARM_ARM_BIT = 16;
	localparam int LATCH_REQ_BIT = 0;
	localparam int LATCH_VALID_BIT = 1;
	localparam int SS_SLEEP_REQUEST = 0;
	localparam int SS_REJECT = 1;
	localparam int SS_WAKE = 2;
	localparam int SS_COPROC_TIMER = 3;
	localparam int SS_TOUCH_TIMER = 4;
	localparam int WAIT_DELAY_LSB = 8;
	localparam int RS_CAUSE_PRI_LSB = 2;
	localparam int RS_CAUSE_SEC_LSB = 8;
	localparam int WS_MASK_LSB = 1;
	localparam int WS_CAUSE_LSB = 12;
	localparam int CAUSE_W = 6;
	localparam int WAKE_W = 11;
	localparam int IRQ_W = 9;

	// irq source bit positions
	localparam int IRQ_MAIN_TIMER = 0;
	localparam int IRQ_TIME_VALID = 4;
	localparam int IRQ_SLEEP_REJECT = 7;
	localparam int IRQ_SLEEP_WAKE = 8;
	// wake source carried by the timer alarm
	localparam int WAKE_ALARM = 10;

	// stable samples a filtered pin wake must show
	localparam logic [3:0] PIN_FILTER_CYCLES = 4'h8;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [0:0] {
		ST_AWAKE = 1'b0,
		ST_SLEEP = 1'b1
	} lpd_state_e;

	// power-force and analogue power controls toward the power switches
	typedef struct packed {
		logic [4:0] ana_power_on;    // per analogue sub-block, 1 = on
		logic plla_force_on;
		logic plla_force_off;
		logic [15:0] force_bits;     // options bits 16..1
	} lpd_pwr_s;

endpackage

// ===== test/lpd_regs_monitor.sv
// checker for the low-power domain register bank
// assumes: bound to lpd_regs, sees only its ports
`timescale 1ns/100ps
`default_nettype none
module lpd_regs_monitor
	import lpd_pkg::*;
(
	input wire logic CLOCK, // clock
	input wire logic RESETN, // reset, active low
	input wire logic [3:0] REG_ADDR, // index
	input wire logic REG_WR, // write strobe
	input wire logic REG_RD, // read strobe
	input wire logic [31:0] REG_WDATA, // write data
	input wire logic [31:0] REG_RDATA, // read data
	input wire logic [IRQ_W-1:0] IRQ_SRC, // raw events
	input wire logic [IRQ_W-1:0] IRQ_OUT, // gated events
	input wire lpd_pwr_s PWR_CTRL, // power controls
	input wire logic SYS_RESET_PULSE, // system reset
	input wire logic PRI_RESET_PULSE, // primary cpu reset
	input wire logic SEC_RESET_PULSE, // secondary cpu reset
	input wire logic CPU_STALL_EN, // stall permit
	input wire logic [1:0] BOOT_VEC_SEL // vector selects
);
	// ----------------------------------------
	// helper logic
	// ----------------------------------------
	logic [IRQ_W-1:0] irq_en_q; // mirror of the enable register
	logic wr_opt; // write to the options word
	assign wr_opt = REG_WR && REG_ADDR == IDX_DOMAIN_OPTIONS;
	// mirror kept here so gating can be judged without the body
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			irq_en_q <= '0;
		end else if (REG_WR && REG_ADDR == IDX_IRQ_ENABLE) begin
			irq_en_q <= REG_WDATA[IRQ_W-1:0];
		end
	end
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (!RESETN);
	// ----------------------------------------
	// assertions
	// ----------------------------------------
	AST_SYS_PULSE: assert property (
		wr_opt && REG_WDATA[0] |=> SYS_RESET_PULSE)
		else $error("system reset pulse missing");
	AST_SYS_CAUSE: assert property (
		SYS_RESET_PULSE |-> $past(wr_opt && REG_WDATA[0]))
		else $error("system reset pulse without write");
	// both cpu pulses follow their trigger bits, and nothing else
	AST_CPU_PULSES: assert property (
		{SEC_RESET_PULSE, PRI_RESET_PULSE} ==
		$past({2{wr_opt}} & REG_WDATA[18:17]))
		else $error("cpu reset pulse differs from write");
	AST_FORCE_BITS: assert property (
		wr_opt |=> PWR_CTRL.force_bits == $past(REG_WDATA[16:1]))
		else $error("force bits differ from write");
	AST_ANA_POWER: assert property (
		REG_WR && REG_ADDR == IDX_ANALOG_POWER_CFG |=>
		{PWR_CTRL.plla_force_off, PWR_CTRL.plla_force_on,
		PWR_CTRL.ana_power_on} == $past(REG_WDATA[6:0]))
		else $error("analogue power differs from write");
	AST_STALL_EN: assert property (
		REG_WR && REG_ADDR == IDX_CPU_STALL_CTRL |=>
		CPU_STALL_EN == $past(REG_WDATA[0]))
		else $error("stall enable differs from write");
	AST_BOOT_VEC: assert property (
		REG_WR && REG_ADDR == IDX_RESET_STATE |=>
		BOOT_VEC_SEL == $past(REG_WDATA[1:0]))
		else $error("vector select differs from write");
	AST_IRQ_GATE: assert property (
		(IRQ_OUT & ~$past(irq_en_q)) == '0)
		else $error("disabled irq raised");
	AST_IRQ_PASS: assert property (
		(IRQ_OUT & 9'h06e) == ($past(IRQ_SRC & irq_en_q) & 9'h06e))
		else $error("enabled external irq not passed");
	AST_RDATA_HOLD: assert property (
		!REG_RD |=> $stable(REG_RDATA))
		else $error("read data changed without read");
	// write, one idle cycle, then a read of the control word
	AST_LATCH_VALID: assert property (
		(REG_WR && REG_ADDR == IDX_TIMER_LATCH_CTRL && REG_WDATA[0])
		##1 (!REG_WR) [*2] ##0 (REG_RD && REG_ADDR == IDX_TIMER_LATCH_CTRL)
		|=> REG_RDATA[1])
		else $error("valid flag not set after latch");
endmodule
bind lpd_regs lpd_regs_monitor u_mon (.CLOCK(CLOCK), .RESETN(RESETN),
	.REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_RD(REG_RD),
	.REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
	.IRQ_SRC(IRQ_SRC), .IRQ_OUT(IRQ_OUT), .PWR_CTRL(PWR_CTRL),
	.SYS_RESET_PULSE(SYS_RESET_PULSE), .CPU_STALL_EN(CPU_STALL_EN),
	.PRI_RESET_PULSE(PRI_RESET_PULSE), .SEC_RESET_PULSE(SEC_RESET_PULSE),
	.BOOT_VEC_SEL(BOOT_VEC_SEL));
`default_nettype wire

// ===== test/lpd_regs_tb_top.sv
// self-checking bench for the low-power domain register bank
// assumes: lpd_pkg compiled first, monitor bound separately
`timescale 1ns/100ps
`default_nettype none
module lpd_regs_tb_top;
	import lpd_pkg::*;
	logic clock = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
	logic slow_clk = 1'b0;
	logic [3:0] reg_addr = 4'h0;
	logic [31:0] reg_wdata = 32'h0, reg_rdata;
	logic [9:0] wake_in = 10'h000;
	logic [5:0] pri_cause = 6'h2d, sec_cause = 6'h13; // fixed causes
	logic [8:0] irq_src = 9'h000, irq_out;
	lpd_pwr_s pwr_ctrl;
	logic sys_p, pri_p, sec_p, stall_en, sleep_active, osc_on, cp_run, tc_run;
	logic [1:0] vsel;
	integer seed = 41620, mismatches = 0, total_checks = 0;
	logic [3:0] addrs [11] = '{4'h0, 4'h1, 4'h2, 4'h7, 4'h8, 4'hb, 4'hc,
		4'hd, 4'hf, 4'h9, 4'ha};
	lpd_regs dut (.CLOCK(clock), .RESETN(resetn), .REG_ADDR(reg_addr),
		.REG_WR(reg_wr), .REG_RD(reg_rd), .REG_WDATA(reg_wdata),
		.REG_RDATA(reg_rdata), .SLOW_CLK(slow_clk), .WAKE_IN(wake_in),
		.PRI_CAUSE_IN(pri_cause), .SEC_CAUSE_IN(sec_cause),
		.IRQ_SRC(irq_src), .IRQ_OUT(irq_out), .PWR_CTRL(pwr_ctrl),
		.SYS_RESET_PULSE(sys_p), .PRI_RESET_PULSE(pri_p),
		.SEC_RESET_PULSE(sec_p), .CPU_STALL_EN(stall_en),
		.BOOT_VEC_SEL(vsel), .SLEEP_ACTIVE(sleep_active), .OSC_ON(osc_on),
		.COPROC_RUN(cp_run), .TOUCH_RUN(tc_run));
	always #2.5 clock = ~clock;
	// random irq events every cycle keep the gating busy
	always @(posedge clock) irq_src <= 9'($random(seed));
	// expected read-back of a word after writing d
	function automatic logic [31:0] expect_val(input logic [3:0] a,
		input logic [31:0] d);
		case (a)
			4'h0: return d & OPT_RW_MASK; // triggers read as zero
			4'h1: return d;
			4'h2: return d & 32'h0001_ffff;
			4'h7: return d & 32'h0000_0001;
			4'h8: return d & 32'h00ff_ffff;
			4'hb: return d & 32'h0000_ffff;
			4'hc: return d & 32'h0000_007f;
			4'hd: return {18'h0, sec_cause, pri_cause, d[1:0]};
			4'hf: return d & 32'h0000_01ff;
			default: return 32'h0; // unmapped words
		endcase
	endfunction
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		@(negedge clock);
		d = reg_rdata;
	endtask
	task automatic chk(input string n, input logic [31:0] s,
		input logic [31:0] e);
		total_checks++;
		if (s !== e) begin
			$display("ERROR %s expected %h seen %h", n, e, s);
			mismatches++;
		end
	endtask
	// slow clock runs only while the bench asks for edges
	task automatic slow(input int n);
		repeat (n) begin
			repeat (4) @(posedge clock);
			slow_clk <= 1'b1;
			repeat (4) @(posedge clock);
			slow_clk <= 1'b0;
		end
	endtask
	task automatic wait_sleep(input logic v);
		for (int i = 0; i < 64 && sleep_active !== v; i++) @(posedge clock);
		chk("sleep state", {31'h0, sleep_active}, {31'h0, v});
		if (sleep_active !== v) complete_run();
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	initial begin
		logic [31:0] v, d;
		logic [3:0] a;
		repeat (16) @(posedge clock);
		resetn <= 1'b1;
		foreach (addrs[k]) begin
			rd(addrs[k], v);
			chk("reset value", v, expect_val(addrs[k], 32'h0));
		end
		// all-ones corner per word first, then random words
		for (int i = 0; i < 35; i++) begin
			a = (i < 11) ? addrs[i] : addrs[$unsigned($random(seed)) % 11];
			d = (i < 11) ? 32'hffff_ffff : $random(seed);
			wr(a, d);
			rd(a, v);
			chk("read back", v, expect_val(a, d));
		end
		slow(5);
		wr(IDX_TIMER_LATCH_CTRL, 32'h1);
		rd(IDX_TIMER_LATCH_CTRL, v);
		chk("latch valid", v, 32'h2);
		rd(IDX_TIMER_VALUE_LOW, v);
		chk("timer low", v, 32'h5);
		rd(IDX_TIMER_VALUE_HIGH, v);
		chk("timer high", v, 32'h0);
		slow(3);
		rd(IDX_TIMER_VALUE_LOW, v);
		chk("timer held", v, 32'h5);
		wr(IDX_TIMER_LATCH_CTRL, 32'h1);
		rd(IDX_TIMER_VALUE_LOW, v);
		chk("timer relatch", v, 32'h8);
		// sleep with wake pending early: minimum count must hold it
		wr(IDX_RESET_STATE, 32'h1);
		wr(IDX_MIN_SLEEP_CFG, 32'h3);
		wr(IDX_WAKEUP_STATE, 32'h4);
		wr(IDX_SLOW_CLOCK_WAIT_CFG, 32'h102); // oscillator 2, start 1
		wr(IDX_IRQ_ENABLE, 32'h100);
		chk("boot vector", {30'h0, vsel}, 32'h1);
		wr(IDX_SLEEP_STATE_CTRL, 32'h19);
		wait_sleep(1'b1);
		wake_in <= 10'h002;
		slow(2);
		// let the second slow edge reach the registered outputs
		repeat (2) @(negedge clock);
		chk("still asleep", {31'h0, sleep_active}, 32'h1);
		chk("osc off", {31'h0, osc_on}, 32'h0);
		chk("coproc run", {31'h0, cp_run}, 32'h1);
		chk("touch run", {31'h0, tc_run}, 32'h1);
		slow(2);
		wait_sleep(1'b0);
		rd(IDX_WAKEUP_STATE, v);
		chk("wake cause", {21'h0, v[22:12]}, 32'h2);
		rd(IDX_SLEEP_STATE_CTRL, v);
		chk("wake flag", v & 32'h4, 32'h4);
		chk("wake irq", {23'h0, irq_out}, 32'h100);
		wr(IDX_SLEEP_STATE_CTRL, 32'h1);
		repeat (3) @(posedge clock);
		rd(IDX_SLEEP_STATE_CTRL, v);
		chk("reject flags", v & 32'h3, 32'h2);
		chk("not asleep", {31'h0, sleep_active}, 32'h0);
		// filtered pin wake: a short run of samples must not wake
		wr(IDX_MIN_SLEEP_CFG, 32'h0);
		wr(IDX_WAKEUP_STATE, 32'h3);
		wr(IDX_SLEEP_STATE_CTRL, 32'h1);
		wait_sleep(1'b1);
		wake_in <= 10'h001;
		repeat (5) @(negedge clock);
		chk("filter holds", {31'h0, sleep_active}, 32'h1);
		wait_sleep(1'b0);
		rd(IDX_WAKEUP_STATE, v);
		chk("pin cause", {21'h0, v[22:12]}, 32'h1);
		// armed alarm wakes once the timer passes 12 slow edges
		wr(IDX_SLEEP_TARGET_LOW, 32'hd);
		wr(IDX_SLEEP_TARGET_HIGH_ALARM, 32'h1_0000);
		wr(IDX_WAKEUP_STATE, 32'h800);
		wr(IDX_SLEEP_STATE_CTRL, 32'h1);
		wait_sleep(1'b1);
		slow(1);
		wait_sleep(1'b0);
		rd(IDX_WAKEUP_STATE, v);
		chk("alarm cause", {21'h0, v[22:12]}, 32'h400);
		complete_run();
	end
endmodule
`default_nettype wire
